//--- core/atc_pkg.sv
// Shared constants and types for the AT channel signal control block
package atc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned AT_CLK_HZ = 8_000_000;
  // Channel clock enable period; rounded up so the channel never runs fast
  localparam int unsigned AT_DIV = (CLK_HZ + AT_CLK_HZ - 1) / AT_CLK_HZ;

  // ----------------------------------------------------------------
  // Register map (Wishbone byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;

  // Control register fields
  localparam int unsigned CTRL_NMI_EN_BIT = 0;
  localparam int unsigned CTRL_CHK_EN_BIT = 1;
  localparam int unsigned CTRL_IO_WAIT_LSB = 4;
  localparam int unsigned CTRL_MEM_WAIT_LSB = 8;
  localparam int unsigned WAIT_W = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0140;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0FF3;

  // Status register fields
  localparam int unsigned STAT_CACHED_BIT = 0;
  localparam int unsigned STAT_FOREIGN_BIT = 1;
  localparam int unsigned STAT_NMI_BIT = 2;
  localparam int unsigned STAT_WIDE_BIT = 3;
  localparam int unsigned STAT_STATE_LSB = 4;

  // ----------------------------------------------------------------
  // Channel address
  // ----------------------------------------------------------------
  localparam int unsigned LA_W = 7;
  localparam logic [3:0] LOW_MEG_PAGE = 4'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_CPU = 2'h0,
    KIND_DMA = 2'h1,
    KIND_REF = 2'h2
  } atc_kind_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ADDR = 4'h2,
    ST_CMD = 4'h4,
    ST_DONE = 4'h8
  } atc_state_e;

endpackage

//--- core/atc_sync.sv
// Two-stage synchroniser for a bundle of channel pins
`timescale 1ns/10ps
`default_nettype none
module atc_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic clk_i,          // System clock
  input wire logic rst_i,          // Synchronous reset
  input wire logic [W-1:0] d_i,    // Asynchronous pin levels
  output logic [W-1:0] q_o         // Synchronised levels
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  if (W < 1) begin : g_chk
    $error("atc_sync: width must be at least one");
  end

  // No reset: a strap must reach the core while reset is still held
  always_ff @(posedge clk_i) begin
    meta_q <= d_i;
    sync_q <= meta_q;
  end

  assign q_o = sync_q;

endmodule
`default_nettype wire

//--- core/atc_tick.sv
// Divider that makes the channel clock enable pulse
`timescale 1ns/10ps
`default_nettype none
module atc_tick #(
  parameter int unsigned DIV = 5
) (
  input wire logic clk_i,  // System clock
  input wire logic rst_i,  // Synchronous reset
  output logic tick_o      // One-cycle enable every DIV cycles
);

  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_q;

  if (DIV < 2) begin : g_chk
    $error("atc_tick: divider must be at least two");
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || cnt_q == LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign tick_o = (cnt_q == LAST);

endmodule
`default_nettype wire

//--- core/atc_channel_ctrl.sv
// AT channel command, address, strobe and wait-state control
//
// Our own choices: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - NMI on channel check when both enables set
// - Channel ready low stretches the cycle
// - Ready high ends after programmed wait states
// - Drive channel ready for internal I/O accesses
// - I/O wide select makes a 16-bit cycle
// - I/O commands driven unless a master owns
// - Early address driven, master input, refresh floats
// - Foreign owner low means master owns bus
// - Memory wide select makes a 16-bit cycle
// - Memory read driven, held high in master refresh
// - Memory write driven unless a master owns
// - Refresh driven by us, master drives its own
// - High address always out, bit 16 master input
// - Byte high enable low wide, else inverse bit0
// - Address bit0 held low in wide DMA
// - CPU cycles drive bit0 and byte high enable
// - Address buffer direction or bit 15 by configuration
// - Data buffer direction follows transfer direction
// - Low-meg read strobe needs read and page zero
// - Low-meg write strobe needs write and page zero
// - Zero wait ends the cycle at once
// - Terminal count shown for the DMA channel
// - Strap sampled in reset picks configuration
module atc_channel_ctrl #(
  parameter int unsigned AT_DIV = atc_pkg::AT_DIV
) (
  input wire logic clk_i,                   // System clock, 40 MHz
  input wire logic rst_i,                   // Synchronous reset, active high
  // Wishbone slave
  input wire logic wb_cyc_i,                // Bus cycle
  input wire logic wb_stb_i,                // Strobe
  input wire logic wb_we_i,                 // Write enable
  input wire logic [atc_pkg::ADDR_W-1:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i,          // Byte lanes
  input wire logic [31:0] wb_dat_i,         // Write data
  output logic [31:0] wb_dat_o,             // Read data
  output logic wb_ack_o,                    // Acknowledge
  // Internal cycle request
  input wire logic req_valid_i,             // Cycle request
  output logic req_ready_o,                 // Request taken this cycle
  input wire logic [1:0] req_kind_i,        // CPU, DMA or refresh
  input wire logic req_io_i,                // I/O rather than memory
  input wire logic req_write_i,             // Write rather than read
  input wire logic req_wide_i,              // 16-bit DMA transfer
  input wire logic req_internal_i,          // I/O to on-chip peripherals
  input wire logic req_bhe_n_i,             // CPU byte high enable
  input wire logic [23:0] req_addr_i,       // Cycle address
  input wire logic dma_tc_i,                // DMA channel at terminal count
  output logic done_o,                      // Cycle finished pulse
  output logic wide_o,                      // Finished cycle was 16-bit
  // Channel pins
  input wire logic io_channel_check_n_i,    // Channel error
  input wire logic foreign_owner_n_i,       // Another master owns bus
  input wire logic zero_wait_n_i,           // End cycle now
  input wire logic io_wide_select_n_i,      // 16-bit I/O
  input wire logic mem_wide_select_n_i,     // 16-bit memory
  input wire logic config_strap_pin_i,      // Configuration strap
  input wire logic channel_ready_i,         // Ready pin in
  output logic channel_ready_o,             // Ready pin out
  output logic channel_ready_oe_o,          // Ready pin enable
  input wire logic io_read_cmd_n_i,         // I/O read in
  output logic io_read_cmd_n_o,             // I/O read out
  input wire logic io_write_cmd_n_i,        // I/O write in
  output logic io_write_cmd_n_o,            // I/O write out
  output logic io_cmd_oe_o,                 // I/O command enable
  input wire logic mem_read_cmd_n_i,        // Memory read in
  output logic mem_read_cmd_n_o,            // Memory read out
  output logic mem_read_oe_o,               // Memory read enable
  input wire logic mem_write_cmd_n_i,       // Memory write in
  output logic mem_write_cmd_n_o,           // Memory write out
  output logic mem_write_oe_o,              // Memory write enable
  input wire logic refresh_n_i,             // Refresh in
  output logic refresh_n_o,                 // Refresh out
  output logic refresh_oe_o,                // Refresh enable
  input wire logic [atc_pkg::LA_W-1:0] high_early_addr_i, // Early address in
  output logic [atc_pkg::LA_W-1:0] high_early_addr_o,     // Early address out
  output logic high_early_addr_oe_o,        // Early address enable
  output logic [2:0] sys_addr_high_o,       // System address 19..17
  input wire logic sys_addr_bit16_i,        // Address 16 in
  output logic sys_addr_bit16_o,            // Address 16 out
  output logic sys_addr_bit16_oe_o,         // Address 16 enable
  input wire logic addr_bit0_i,             // Address 0 in
  output logic addr_bit0_o,                 // Address 0 out
  output logic addr_bit0_oe_o,              // Address 0 enable
  input wire logic byte_high_enable_n_i,    // Byte high enable in
  output logic byte_high_enable_n_o,        // Byte high enable out
  output logic byte_high_enable_oe_o,       // Byte high enable enable
  output logic addr_buffer_dir_o,           // Buffer direction or bit 15
  output logic [1:0] data_buffer_dir_o,     // Data buffer direction
  output logic low_meg_read_n_o,            // Low-meg read strobe
  output logic low_meg_write_n_o,           // Low-meg write strobe
  output logic terminal_count_o,            // DMA terminal count
  output logic nmi_o                        // Non-maskable interrupt
);

  // ----------------------------------------------------------------
  // Pin synchronisers and channel clock enable
  // ----------------------------------------------------------------
  localparam int unsigned SW = 14 + atc_pkg::LA_W;

  logic [SW-1:0] pins_s;
  logic chk_n_s, foreign_n_s, zws_n_s, ready_s, iow16_n_s, memw16_n_s, strap_s;
  logic ior_in_s, iow_in_s, mem_read_cmd_n_in_s, mem_write_cmd_n_in_s, ref_in_s, sys_addr_bit16_in_s, sa0_in_s;
  logic [atc_pkg::LA_W-1:0] la_in_s;
  logic at_tick;

  if (AT_DIV < 2) begin : g_chk
    $error("atc_channel_ctrl: channel clock divider too small");
  end

  atc_sync #(.W(SW), .INIT({SW{1'b1}})) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({io_channel_check_n_i, foreign_owner_n_i, zero_wait_n_i, channel_ready_i,
          io_wide_select_n_i, mem_wide_select_n_i, config_strap_pin_i,
          io_read_cmd_n_i, io_write_cmd_n_i, mem_read_cmd_n_i, mem_write_cmd_n_i,
          refresh_n_i, sys_addr_bit16_i, addr_bit0_i, high_early_addr_i}),
    .q_o(pins_s)
  );

  assign {chk_n_s, foreign_n_s, zws_n_s, ready_s, iow16_n_s, memw16_n_s, strap_s,
          ior_in_s, iow_in_s, mem_read_cmd_n_in_s, mem_write_cmd_n_in_s, ref_in_s, sys_addr_bit16_in_s, sa0_in_s,
          la_in_s} = pins_s;

  atc_tick #(.DIV(AT_DIV)) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(at_tick)
  );

  // ----------------------------------------------------------------
  // Configuration strap and bus ownership
  // ----------------------------------------------------------------
  logic cached_q;
  wire master = ~foreign_n_s;

  // Strap is followed while reset is held and frozen at release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cached_q <= ~strap_s;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] wb_dat_q;
  logic wb_ack_q;
  logic nmi_q;

  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_q;
  wire sel_ctrl = (wb_adr_i == atc_pkg::REG_CTRL);
  wire sel_stat = (wb_adr_i == atc_pkg::REG_STATUS);
  wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] ctrl_d = ((ctrl_q & ~wmask) | (wb_dat_i & wmask)) & atc_pkg::CTRL_MASK;
  wire nmi_en = ctrl_q[atc_pkg::CTRL_NMI_EN_BIT];
  wire chk_en = ctrl_q[atc_pkg::CTRL_CHK_EN_BIT];
  wire [atc_pkg::WAIT_W-1:0] io_waits = ctrl_q[atc_pkg::CTRL_IO_WAIT_LSB +: atc_pkg::WAIT_W];
  wire [atc_pkg::WAIT_W-1:0] mem_waits = ctrl_q[atc_pkg::CTRL_MEM_WAIT_LSB +: atc_pkg::WAIT_W];

  logic [31:0] status;
  logic wide_q;
  atc_pkg::atc_state_e state_q;

  always_comb begin
    status = '0;
    status[atc_pkg::STAT_CACHED_BIT] = cached_q;
    status[atc_pkg::STAT_FOREIGN_BIT] = master;
    status[atc_pkg::STAT_NMI_BIT] = nmi_q;
    status[atc_pkg::STAT_WIDE_BIT] = wide_q;
    status[atc_pkg::STAT_STATE_LSB +: 4] = state_q;
  end

  wire [31:0] rd_data = sel_ctrl ? ctrl_q : (sel_stat ? status : 32'h0000_0000);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= atc_pkg::CTRL_RESET;
      wb_ack_q <= 1'b0;
      wb_dat_q <= '0;
    end else begin
      wb_ack_q <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_q <= rd_data;
      end
      if (wb_req && wb_we_i && sel_ctrl) begin
        ctrl_q <= ctrl_d;
      end
    end
  end

  assign wb_ack_o = wb_ack_q;
  assign wb_dat_o = wb_dat_q;

  // ----------------------------------------------------------------
  // Channel check NMI
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nmi_q <= 1'b0;
    end else begin
      nmi_q <= nmi_en & chk_en & ~chk_n_s;
    end
  end

  assign nmi_o = nmi_q;

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  logic [1:0] kind_q;
  logic io_q, write_q, dma_wide_q, internal_q, bhe_n_q, done_q;
  logic [23:0] addr_q;
  logic [atc_pkg::WAIT_W-1:0] wait_q;

  wire busy = (state_q == atc_pkg::ST_ADDR) || (state_q == atc_pkg::ST_CMD);
  wire in_cmd = (state_q == atc_pkg::ST_CMD);
  wire is_dma = (kind_q == atc_pkg::KIND_DMA);
  wire is_ref = (kind_q == atc_pkg::KIND_REF);
  wire is_cpu = (kind_q == atc_pkg::KIND_CPU);
  wire chan_wide = io_q ? ~iow16_n_s : ~memw16_n_s;
  wire wide_now = is_dma ? dma_wide_q : (~is_ref & chan_wide);
  wire [atc_pkg::WAIT_W-1:0] waits = io_q ? io_waits : mem_waits;
  wire take = req_ready_o & req_valid_i;

  assign req_ready_o = (state_q == atc_pkg::ST_IDLE) & ~master;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= atc_pkg::ST_IDLE;
      kind_q <= atc_pkg::KIND_CPU;
      io_q <= 1'b0;
      write_q <= 1'b0;
      dma_wide_q <= 1'b0;
      internal_q <= 1'b0;
      bhe_n_q <= 1'b1;
      addr_q <= '0;
      wait_q <= '0;
      wide_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        atc_pkg::ST_IDLE: begin
          if (take) begin
            kind_q <= req_kind_i;
            io_q <= req_io_i;
            write_q <= req_write_i;
            dma_wide_q <= req_wide_i;
            internal_q <= req_internal_i;
            bhe_n_q <= req_bhe_n_i;
            addr_q <= req_addr_i;
            state_q <= atc_pkg::ST_ADDR;
          end
        end
        atc_pkg::ST_ADDR: begin
          if (at_tick) begin
            wait_q <= waits;
            state_q <= atc_pkg::ST_CMD;
          end
        end
        atc_pkg::ST_CMD: begin
          if (at_tick) begin
            if (!ready_s && !channel_ready_oe_o) begin
              state_q <= atc_pkg::ST_CMD;
            end else if (!zws_n_s || wait_q == '0) begin
              state_q <= atc_pkg::ST_DONE;
              done_q <= 1'b1;
              wide_q <= wide_now;
            end else begin
              wait_q <= wait_q - 1'b1;
            end
          end
        end
        atc_pkg::ST_DONE: begin
          state_q <= atc_pkg::ST_IDLE;
        end
        default: begin
          state_q <= atc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign done_o = done_q;
  assign wide_o = wide_q;

  // ----------------------------------------------------------------
  // Command, address and direction pins
  // ----------------------------------------------------------------
  wire own = ~master;
  wire my_ior = in_cmd & io_q & ~write_q & ~is_ref;
  wire my_iow = in_cmd & io_q & write_q & ~is_ref;
  wire my_mem_read_cmd_n = in_cmd & ((~io_q & ~write_q) | is_ref);
  wire my_mem_write_cmd_n = in_cmd & ~io_q & write_q & ~is_ref;
  wire master_ref = master & ~ref_in_s;

  assign io_cmd_oe_o = own;
  assign io_read_cmd_n_o = ~my_ior;
  assign io_write_cmd_n_o = ~my_iow;
  assign mem_read_oe_o = own | master_ref;
  assign mem_read_cmd_n_o = master ? 1'b1 : ~my_mem_read_cmd_n;
  assign mem_write_oe_o = own;
  assign mem_write_cmd_n_o = ~my_mem_write_cmd_n;
  assign refresh_oe_o = own;
  assign refresh_n_o = ~(busy & is_ref);

  assign high_early_addr_oe_o = own & ~(busy & is_ref);
  assign high_early_addr_o = addr_q[23:17];
  assign sys_addr_high_o = addr_q[19:17];
  assign sys_addr_bit16_oe_o = own;
  assign sys_addr_bit16_o = addr_q[16];

  // Byte steering: CPU passes its own enable, DMA and masters follow width
  wire master_wide = ~iow16_n_s | ~memw16_n_s;
  wire dma_wide_cyc = is_dma & dma_wide_q;
  assign addr_bit0_oe_o = own;
  assign addr_bit0_o = dma_wide_cyc ? 1'b0 : addr_q[0];
  assign byte_high_enable_oe_o = 1'b1;
  assign byte_high_enable_n_o = master ? (master_wide ? 1'b0 : ~sa0_in_s) :
                                is_cpu ? bhe_n_q :
                                is_dma ? (dma_wide_q ? 1'b0 : ~addr_q[0]) : 1'b1;

  assign addr_buffer_dir_o = cached_q ? own : addr_q[15];
  wire drive_out = own ? write_q : ~(ior_in_s & mem_read_cmd_n_in_s);
  assign data_buffer_dir_o = {2{drive_out}};

  // ----------------------------------------------------------------
  // Ready drive, low-meg strobes, terminal count
  // ----------------------------------------------------------------
  assign channel_ready_oe_o = busy & io_q & internal_q & own;
  assign channel_ready_o = in_cmd & (wait_q == '0);

  logic lmr_n_q, lmw_n_q, tc_q;
  wire [3:0] page = master ? la_in_s[6:3] : addr_q[23:20];
  wire page0 = (page == atc_pkg::LOW_MEG_PAGE);
  wire mem_read_cmd_n_act = master ? ~mem_read_cmd_n_in_s : my_mem_read_cmd_n;
  wire mem_write_cmd_n_act = master ? ~mem_write_cmd_n_in_s : my_mem_write_cmd_n;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lmr_n_q <= 1'b1;
      lmw_n_q <= 1'b1;
      tc_q <= 1'b0;
    end else begin
      lmr_n_q <= ~(mem_read_cmd_n_act & page0);
      lmw_n_q <= ~(mem_write_cmd_n_act & page0);
      tc_q <= dma_tc_i & is_dma & busy;
    end
  end

  assign low_meg_read_n_o = lmr_n_q;
  assign low_meg_write_n_o = lmw_n_q;
  assign terminal_count_o = tc_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_cmd_tick_ready;
    in_cmd && at_tick && ready_s;
  endsequence

  a_nmi_gate: assert property (nmi_o |-> $past(nmi_en && chk_en && !chk_n_s))
    else $error("nmi raised without both enables and a check");
  a_ready_stall: assert property (in_cmd && at_tick && !ready_s && !channel_ready_oe_o |=> in_cmd)
    else $error("cycle ended while channel ready was low");
  a_wait_count: assert property (s_cmd_tick_ready and zws_n_s && wait_q != '0 |=> in_cmd)
    else $error("cycle ended before programmed wait states");
  a_zero_wait_end: assert property (s_cmd_tick_ready and !zws_n_s |=> state_q == atc_pkg::ST_DONE ##1 done_q == 1'b0)
    else $error("zero wait did not end the cycle");
  a_ready_drive: assert property (channel_ready_oe_o |-> io_q && internal_q && busy)
    else $error("channel ready driven outside internal I/O");
  a_master_float: assert property (master |-> !io_cmd_oe_o && !mem_write_oe_o && !sys_addr_bit16_oe_o)
    else $error("command or address driven during master cycle");
  a_refresh_float: assert property (busy && is_ref |-> !high_early_addr_oe_o && !refresh_n_o)
    else $error("early address driven in refresh");
  a_master_refresh: assert property (master && !ref_in_s |-> mem_read_oe_o)
    else $error("memory read not driven in master refresh");
  a_wide_dma: assert property (dma_wide_cyc && own |-> !byte_high_enable_n_o && !addr_bit0_o)
    else $error("wide dma byte steering wrong");
  a_low_meg_read: assert property (!low_meg_read_n_o |-> $past(mem_read_cmd_n_act && page0))
    else $error("low-meg read without read or page zero");
  a_tc_dma: assert property (terminal_count_o |-> $past(is_dma && dma_tc_i))
    else $error("terminal count outside dma");

endmodule
`default_nettype wire

//--- test/atc_card_model.sv
// Expansion card model answering channel cycles
`timescale 1ns/10ps
`default_nettype none
module atc_card_model (
  input wire logic clk_i,        // System clock
  input wire logic sel_i,        // Card addressed
  input wire logic io_i,         // Cycle is I/O
  input wire logic wide_i,       // Card is 16-bit
  input wire logic fast_i,       // Card asks zero wait
  input wire logic [3:0] slow_i, // Cycles ready held low
  output logic rdy_o,            // Ready, pulled up
  output logic zws_n_o,          // Zero wait, pulled up
  output logic iow_n_o,          // I/O wide select
  output logic mw_n_o            // Memory wide select
);
  logic [3:0] cnt_q;
  always_ff @(posedge clk_i) begin
    cnt_q <= sel_i ? cnt_q - {3'h0, cnt_q != 4'h0} : slow_i;
  end
  assign rdy_o = !(sel_i && cnt_q != 4'h0);
  assign zws_n_o = !(sel_i && fast_i);
  assign iow_n_o = !(sel_i && io_i && wide_i);
  assign mw_n_o = !(sel_i && !io_i && wide_i);
endmodule
`default_nettype wire

//--- test/at_channel_signal_control_tb.sv
// Self-checking bench for the AT channel signal control block
`timescale 1ns/10ps
`default_nettype none
module at_channel_signal_control_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, req_valid_i = 1'b0, req_io_i = 1'b0, req_write_i = 1'b0;
  logic req_wide_i = 1'b0, req_internal_i = 1'b0, req_bhe_n_i = 1'b0, dma_tc_i = 1'b0, io_channel_check_n_i = 1'b1;
  logic foreign_owner_n_i = 1'b1, config_strap_pin_i = 1'b0, sel = 1'b0, card_wide = 1'b0, card_fast = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF, slow = 4'h0;
  logic [1:0] req_kind_i = 2'h0;
  logic [23:0] req_addr_i = 24'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, req_ready_o, done_o, wide_o, channel_ready_o, channel_ready_oe_o, io_read_cmd_n_o, io_write_cmd_n_o;
  logic io_cmd_oe_o, mem_read_cmd_n_o, mem_read_oe_o, mem_write_cmd_n_o, mem_write_oe_o, refresh_n_o, refresh_oe_o;
  logic high_early_addr_oe_o, sys_addr_bit16_o, sys_addr_bit16_oe_o, addr_bit0_o, addr_bit0_oe_o, byte_high_enable_n_o;
  logic byte_high_enable_oe_o, addr_buffer_dir_o, low_meg_read_n_o, low_meg_write_n_o, terminal_count_o, nmi_o;
  logic [6:0] high_early_addr_o;
  logic [2:0] sys_addr_high_o;
  logic [1:0] data_buffer_dir_o, sdir_cmd;
  logic [9:0] seen;
  int miscompares = 0;
  int check_count = 0;
  wire logic card_rdy, zero_wait_n_i, io_wide_select_n_i, mem_wide_select_n_i;
  wire logic channel_ready_i = channel_ready_oe_o ? channel_ready_o : card_rdy;
  wire logic io_read_cmd_n_i = io_read_cmd_n_o | ~io_cmd_oe_o;
  wire logic io_write_cmd_n_i = io_write_cmd_n_o | ~io_cmd_oe_o;
  wire logic mem_read_cmd_n_i = mem_read_cmd_n_o | ~mem_read_oe_o;
  wire logic mem_write_cmd_n_i = mem_write_cmd_n_o | ~mem_write_oe_o;
  wire logic refresh_n_i = refresh_n_o | ~refresh_oe_o;
  wire logic [6:0] high_early_addr_i = high_early_addr_o ^ {7{~high_early_addr_oe_o}};
  wire logic sys_addr_bit16_i = sys_addr_bit16_o ^ ~sys_addr_bit16_oe_o;
  wire logic addr_bit0_i = addr_bit0_o ^ ~addr_bit0_oe_o;
  wire logic byte_high_enable_n_i = byte_high_enable_n_o | ~byte_high_enable_oe_o;

  atc_channel_ctrl #(.AT_DIV(2)) dut (.*);
  atc_card_model card (.clk_i(clk_i), .sel_i(sel), .io_i(req_io_i), .wide_i(card_wide), .fast_i(card_fast),
    .slow_i(slow), .rdy_o(card_rdy), .zws_n_o(zero_wait_n_i), .iow_n_o(io_wide_select_n_i),
    .mw_n_o(mem_wide_select_n_i));

  always #12.5 clk_i = ~clk_i;

  // Collect what the pins showed during a cycle
  always @(negedge clk_i) begin
    if (~(mem_read_cmd_n_i & mem_write_cmd_n_i & io_read_cmd_n_i & io_write_cmd_n_i)) begin
      seen <= seen | {~low_meg_read_n_o, ~low_meg_write_n_o, channel_ready_oe_o, addr_bit0_oe_o & addr_bit0_o,
        ~byte_high_enable_n_i, terminal_count_o, high_early_addr_oe_o, ~refresh_n_i, ~mem_read_cmd_n_i,
        ~(io_read_cmd_n_i & io_write_cmd_n_i)};
      sdir_cmd <= data_buffer_dir_o;
    end
  end

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic timeout(input logic ok);
    if (ok !== 1'b1) begin
      miscompares++;
      summarize();
    end
  endtask

  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    n = 0;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 20);
    timeout(wb_ack_o);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask

  task automatic run(input logic [1:0] k, input logic io, wr, wd, it, input logic [23:0] a, output int n);
    @(posedge clk_i);
    {req_valid_i, req_kind_i, req_io_i, req_write_i, req_wide_i, req_internal_i, req_addr_i, sel} <=
      {1'b1, k, io, wr, wd, it, a, 1'b1};
    seen = 10'h0;
    n = 0;
    do begin @(posedge clk_i); n++; end while (req_ready_o !== 1'b1 && n < 99);
    timeout(req_ready_o);
    req_valid_i <= 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 199) begin @(negedge clk_i); n++; end
    timeout(done_o);
    @(posedge clk_i);
    sel <= 1'b0;
  endtask

  initial begin
    logic [31:0] rd;
    int lf, ls, lz, l8;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, atc_pkg::REG_CTRL, 0, rd);
    check("ctrl reset", rd, atc_pkg::CTRL_RESET);
    wb(0, atc_pkg::REG_STATUS, 0, rd);
    check("cached strap", rd[0], 1);
    wb(0, 4'hC, 0, rd);
    check("unmapped", rd, 0);
    wb(1, atc_pkg::REG_CTRL, 32'hFFFF_F213, rd);
    wb(0, atc_pkg::REG_CTRL, 0, rd);
    check("ctrl mask", rd, 32'h0000_0213);
    io_channel_check_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    check("nmi on", nmi_o, 1);
    wb(1, atc_pkg::REG_CTRL, 32'h0000_0211, rd);
    repeat (6) @(posedge clk_i);
    check("nmi off", nmi_o, 0);
    io_channel_check_n_i <= 1'b1;
    $display("test registers and nmi done");
    for (int i = 0; i < 4; i++) begin
      card_wide <= i[0];
      run(2'h0, 0, i[0], 0, 0, i[1] ? 24'h12_3456 : 24'h01_2344, lf);
      check("low meg read", seen[9], !i[0] && !i[1]);
      check("low meg write", seen[8], i[0] && !i[1]);
      check("mem wide", wide_o, i[0]);
      check("data dir", sdir_cmd, {2{i[0]}});
    end
    $display("test memory cycles done");
    card_wide <= 1'b0;
    run(2'h0, 0, 0, 0, 0, 24'h01_2340, lf);
    check("cpu early addr", seen[3], 1);
    slow <= 4'hF;
    run(2'h0, 0, 0, 0, 0, 24'h01_2340, ls);
    check("ready stretch", ls > lf + 4, 1);
    card_fast <= 1'b1;
    run(2'h0, 0, 0, 0, 0, 24'h01_2340, ls);
    check("ready over zero wait", ls > lf + 4, 1);
    slow <= 4'h0;
    run(2'h0, 0, 0, 0, 0, 24'h01_2340, lz);
    check("zero wait", lz < lf, 1);
    card_fast <= 1'b0;
    wb(1, atc_pkg::REG_CTRL, 32'h0000_0811, rd);
    run(2'h0, 0, 0, 0, 0, 24'h01_2340, l8);
    check("wait count", (l8 - lf) inside {[10:14]}, 1);
    $display("test wait states done");
    card_wide <= 1'b1;
    run(2'h0, 1, 0, 0, 0, 24'h00_0300, ls);
    check("io wide", wide_o, 1);
    check("io ready input", seen[7], 0);
    check("io cmd driven", seen[0], 1);
    card_wide <= 1'b0;
    run(2'h0, 1, 1, 0, 1, 24'h00_0020, ls);
    check("io ready output", seen[7], 1);
    dma_tc_i <= 1'b1;
    run(2'h1, 0, 0, 1, 0, 24'h00_4001, ls);
    check("dma bit0 low", seen[6], 0);
    check("dma bhe low", seen[5], 1);
    check("terminal count", seen[4], 1);
    dma_tc_i <= 1'b0;
    run(2'h2, 0, 0, 0, 0, 24'h00_0000, ls);
    check("refresh floats la", seen[3], 0);
    check("refresh driven", seen[2], 1);
    check("refresh mem read", seen[1], 1);
    $display("test io dma refresh done");
    check("sa dir owned", addr_buffer_dir_o, 1);
    foreign_owner_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    check("master no take", req_ready_o, 0);
    check("master io cmd", io_cmd_oe_o, 0);
    check("master mem write", mem_write_oe_o, 0);
    check("master sys_addr_bit16", sys_addr_bit16_oe_o, 0);
    check("sa dir master", addr_buffer_dir_o, 0);
    foreign_owner_n_i <= 1'b1;
    $display("test master done");
    summarize();
  end
endmodule
`default_nettype wire
